// File: core/lfc_consts.vh
// Register offsets, field positions and timing counts of the slow clock controller
`ifndef LFC_CONSTS_VH
`define LFC_CONSTS_VH
`define LFC_START_FAST_TASK   12'h000
`define LFC_STOP_FAST_TASK    12'h004
`define LFC_START_SLOW_TASK   12'h008
`define LFC_STOP_SLOW_TASK    12'h00c
`define LFC_CAL_TASK          12'h010
`define LFC_TMR_START_TASK    12'h014
`define LFC_TMR_STOP_TASK     12'h018
`define LFC_FAST_STARTED_EVT  12'h100
`define LFC_SLOW_STARTED_EVT  12'h104
`define LFC_CAL_DONE_EVT      12'h10c
`define LFC_TIMEOUT_EVT       12'h110
`define LFC_INTEN_SET         12'h304
`define LFC_INTEN_CLR         12'h308
`define LFC_FAST_RUN          12'h408
`define LFC_FAST_STAT         12'h40c
`define LFC_SLOW_RUN          12'h414
`define LFC_SLOW_STAT         12'h418
`define LFC_SRC_SNAP          12'h41c
`define LFC_SRC_SEL           12'h518
`define LFC_CAL_IV            12'h538
`define LFC_SYS_OFF           12'h600
// Source select fields
`define LFC_SRC_LSB           0
`define LFC_BYPASS_BIT        16
`define LFC_EXTERNAL_BIT      17
`define LFC_SRC_RC            2'h0
`define LFC_SRC_XTAL          2'h1
`define LFC_SRC_SYNTH         2'h2
// Status fields
`define LFC_STATE_BIT         16
`define LFC_IV_RESET          7'h00
// Timing: slow tick 30517 ns at 100 ns clock
`define LFC_SLOW_PERIOD_NS    30517
`define LFC_CLK_NS            100
`define LFC_SLOW_DIV          (`LFC_SLOW_PERIOD_NS / `LFC_CLK_NS)
`define LFC_XTAL_START_TICKS  16
`define LFC_CAL_TICKS         8
`endif

// File: core/lfc_ctrl.v
// Slow clock controller: source select, start/stop, RC calibration and interval timer
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "lfc_consts.vh"
module lfc_ctrl #(
  parameter SLOW_DIV    = `LFC_SLOW_DIV,
  parameter XTAL_TICKS  = `LFC_XTAL_START_TICKS,
  parameter CAL_TICKS   = `LFC_CAL_TICKS,
  parameter FAST_TICKS  = 4
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        xtal_ready_pin,
  output reg         slow_rc_en,
  output reg         slow_crystal_en,
  output reg         slow_crystal_ext,
  output reg         slow_crystal_bypass,
  output reg         slow_synth_en,
  output reg         fast_clock_req,
  output reg         fast_crystal_en,
  output reg         slow_tick,
  output reg         cal_active
);
  localparam ST_OFF   = 3'b001;
  localparam ST_START = 3'b010;
  localparam ST_RUN   = 3'b100;

  reg [2:0]  state_q;
  reg        run_req_q;
  reg        on_xtal_q;
  reg [17:0] src_sel_q;
  reg [17:0] src_snap_q;
  reg [1:0]  act_src_q;
  reg        sys_off_q;
  reg        fast_run_q;
  reg        fast_up_q;
  reg [7:0]  fast_cnt_q;
  reg [7:0]  xtal_cnt_q;
  reg [7:0]  cal_cnt_q;
  reg [6:0]  iv_q;
  reg [6:0]  tmr_q;
  reg        tmr_run_q;
  reg [15:0] div_q;
  reg [3:0]  evt_q;
  reg [3:0]  inten_q;
  reg        cal_pend_q;
  reg        start_pend_q;
  reg        stop_pend_q;
  reg        xrdy_meta_q;
  reg        xrdy_q;

  wire       wr = psel & penable & pwrite;
  wire       t_fstart = wr && paddr == `LFC_START_FAST_TASK && pwdata[0];
  wire       t_fstop = wr && paddr == `LFC_STOP_FAST_TASK && pwdata[0];
  wire       t_start = wr && paddr == `LFC_START_SLOW_TASK && pwdata[0];
  wire       t_stop = wr && paddr == `LFC_STOP_SLOW_TASK && pwdata[0];
  wire       t_cal = wr && paddr == `LFC_CAL_TASK && pwdata[0];
  wire       t_tstart = wr && paddr == `LFC_TMR_START_TASK && pwdata[0];
  wire       t_tstop = wr && paddr == `LFC_TMR_STOP_TASK && pwdata[0];
  wire       running = state_q != ST_OFF;
  wire       tick = div_q == 16'h0000;
  wire [1:0] wsrc = pwdata[1:0];
  // Writes with the reserved code, or with bypass or external bits the source does not allow, are dropped
  wire       wsrc_ok = (wsrc == `LFC_SRC_XTAL) ? !(!pwdata[`LFC_EXTERNAL_BIT] &&
                       pwdata[`LFC_BYPASS_BIT]) : (wsrc != 2'h3 &&
                       !pwdata[`LFC_EXTERNAL_BIT] && !pwdata[`LFC_BYPASS_BIT]);
  reg  [3:0] evt_set;
  reg  [31:0] rd;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xrdy_meta_q <= 1'b0;
      xrdy_q      <= 1'b0;
    end
    else
    begin
      xrdy_meta_q <= xtal_ready_pin;
      xrdy_q      <= xrdy_meta_q;
    end
  end

  // Slow tick divider: only runs while a slow source is on
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= 16'h0000;
    else if (!running || tick)
      div_q <= SLOW_DIV[15:0] - 16'h0001;
    else
      div_q <= div_q - 16'h0001;
  end

  always @*
  begin
    evt_set = 4'h0;
    if (fast_run_q && !fast_up_q && fast_cnt_q == FAST_TICKS[7:0])
      evt_set[0] = 1'b1;
    if (state_q == ST_START && tick && act_src_q == `LFC_SRC_XTAL &&
        xtal_cnt_q == XTAL_TICKS[7:0] && xrdy_q)
      evt_set[1] = 1'b1;
    if (state_q == ST_START && tick && act_src_q != `LFC_SRC_XTAL)
      evt_set[1] = 1'b1;
    if (cal_active && tick && cal_cnt_q == 8'h01)
      evt_set[2] = 1'b1;
    if (tmr_run_q && tick && tmr_q == 7'h01)
      evt_set[3] = 1'b1;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q      <= ST_OFF;
      run_req_q    <= 1'b0;
      on_xtal_q    <= 1'b0;
      src_sel_q    <= 18'h00000;
      src_snap_q   <= 18'h00000;
      act_src_q    <= `LFC_SRC_RC;
      sys_off_q    <= 1'b0;
      fast_run_q   <= 1'b0;
      fast_up_q    <= 1'b0;
      fast_cnt_q   <= 8'h00;
      xtal_cnt_q   <= 8'h00;
      cal_cnt_q    <= 8'h00;
      cal_active   <= 1'b0;
      iv_q         <= `LFC_IV_RESET;
      tmr_q        <= 7'h00;
      tmr_run_q    <= 1'b0;
      evt_q        <= 4'h0;
      inten_q      <= 4'h0;
      cal_pend_q   <= 1'b0;
      start_pend_q <= 1'b0;
      stop_pend_q  <= 1'b0;
    end
    else if (sys_off_q)
    begin
      state_q    <= ST_OFF;
      run_req_q  <= 1'b0;
      on_xtal_q  <= 1'b0;
      cal_active <= 1'b0;
      tmr_run_q  <= 1'b0;
      fast_run_q <= 1'b0;
      fast_up_q  <= 1'b0;
      if (wr && paddr == `LFC_SYS_OFF)
        sys_off_q <= pwdata[0];
    end
    else
    begin
      if (wr && paddr == `LFC_SYS_OFF)
        sys_off_q <= pwdata[0];
      if (wr && paddr == `LFC_SRC_SEL && !running && wsrc_ok)
        src_sel_q <= pwdata[17:0];
      if (wr && paddr == `LFC_CAL_IV)
        iv_q <= pwdata[6:0];
      if (wr && paddr == `LFC_INTEN_SET)
        inten_q <= inten_q | {pwdata[4:3], pwdata[1:0]};
      if (wr && paddr == `LFC_INTEN_CLR)
        inten_q <= inten_q & ~{pwdata[4:3], pwdata[1:0]};
      // Fast crystal start-up
      if (t_fstart)
        fast_run_q <= 1'b1;
      else if (t_fstop)
      begin
        fast_run_q <= 1'b0;
        fast_up_q  <= 1'b0;
      end
      if (!fast_run_q)
        fast_cnt_q <= 8'h00;
      else if (!fast_up_q && fast_cnt_q == FAST_TICKS[7:0])
        fast_up_q <= 1'b1;
      else if (!fast_up_q)
        fast_cnt_q <= fast_cnt_q + 8'h01;
      // Slow clock start and stop
      if (t_start)
      begin
        run_req_q  <= 1'b1;
        src_snap_q <= src_sel_q;
        if (!running)
        begin
          act_src_q  <= src_sel_q[1:0];
          state_q    <= ST_START;
          on_xtal_q  <= 1'b0;
          xtal_cnt_q <= 8'h00;
        end
      end
      else if (t_stop)
      begin
        run_req_q  <= 1'b0;
        state_q    <= ST_OFF;
        on_xtal_q  <= 1'b0;
        cal_active <= 1'b0;
      end
      else
      begin
        case (state_q)
          ST_OFF:
            state_q <= ST_OFF;
          ST_START:
          begin
            if (tick && act_src_q == `LFC_SRC_XTAL)
            begin
              if (xtal_cnt_q != XTAL_TICKS[7:0])
                xtal_cnt_q <= xtal_cnt_q + 8'h01;
              else if (xrdy_q)
              begin
                on_xtal_q <= 1'b1;
                state_q   <= ST_RUN;
              end
            end
            else if (tick)
              state_q <= ST_RUN;
          end
          ST_RUN:
            state_q <= ST_RUN;
          default:
            state_q <= ST_OFF;
        endcase
      end
      // Calibration and timer tasks are taken only once per slow period
      if (t_cal)
        cal_pend_q <= 1'b1;
      if (t_tstart)
        start_pend_q <= 1'b1;
      if (t_tstop)
        stop_pend_q <= 1'b1;
      if (tick && running)
      begin
        // A task landing on the tick itself is kept for the next tick
        cal_pend_q   <= t_cal;
        start_pend_q <= t_tstart;
        stop_pend_q  <= t_tstop;
        if (cal_pend_q && state_q == ST_RUN && act_src_q == `LFC_SRC_RC && fast_up_q)
        begin
          cal_active <= 1'b1;
          cal_cnt_q  <= CAL_TICKS[7:0];
        end
        else if (cal_active)
        begin
          cal_cnt_q <= cal_cnt_q - 8'h01;
          if (cal_cnt_q == 8'h01)
            cal_active <= 1'b0;
        end
        if (stop_pend_q)
          tmr_run_q <= 1'b0;
        else if (start_pend_q)
        begin
          tmr_run_q <= 1'b1;
          tmr_q     <= iv_q;
        end
        else if (tmr_run_q)
        begin
          tmr_q <= tmr_q - 7'h01;
          if (tmr_q <= 7'h01)
            tmr_run_q <= 1'b0;
        end
      end
      // Hardware set wins over a software clear
      if (wr && paddr == `LFC_FAST_STARTED_EVT)
        evt_q[0] <= pwdata[0] | evt_set[0];
      else if (evt_set[0])
        evt_q[0] <= 1'b1;
      if (wr && paddr == `LFC_SLOW_STARTED_EVT)
        evt_q[1] <= pwdata[0] | evt_set[1];
      else if (evt_set[1])
        evt_q[1] <= 1'b1;
      if (wr && paddr == `LFC_CAL_DONE_EVT)
        evt_q[2] <= pwdata[0] | evt_set[2];
      else if (evt_set[2])
        evt_q[2] <= 1'b1;
      if (wr && paddr == `LFC_TIMEOUT_EVT)
        evt_q[3] <= pwdata[0] | evt_set[3];
      else if (evt_set[3])
        evt_q[3] <= 1'b1;
    end
  end

  always @*
  begin
    rd = 32'h00000000;
    case (paddr)
      `LFC_FAST_STARTED_EVT: rd[0] = evt_q[0];
      `LFC_SLOW_STARTED_EVT: rd[0] = evt_q[1];
      `LFC_CAL_DONE_EVT:     rd[0] = evt_q[2];
      `LFC_TIMEOUT_EVT:      rd[0] = evt_q[3];
      `LFC_INTEN_SET:        rd[4:0] = {inten_q[3:2], 1'b0, inten_q[1:0]};
      `LFC_INTEN_CLR:        rd[4:0] = {inten_q[3:2], 1'b0, inten_q[1:0]};
      `LFC_FAST_RUN:         rd[0] = fast_run_q;
      `LFC_FAST_STAT:
      begin
        rd[0]              = fast_up_q;
        rd[`LFC_STATE_BIT] = fast_up_q;
      end
      `LFC_SLOW_RUN:         rd[0] = run_req_q;
      `LFC_SLOW_STAT:
      begin
        rd[1:0]            = on_xtal_q ? `LFC_SRC_XTAL :
                             (act_src_q == `LFC_SRC_XTAL ? `LFC_SRC_RC : act_src_q);
        rd[`LFC_STATE_BIT] = running;
      end
      `LFC_SRC_SNAP:         rd[17:0] = src_snap_q;
      `LFC_SRC_SEL:          rd[17:0] = src_sel_q;
      `LFC_CAL_IV:           rd[6:0] = iv_q;
      `LFC_SYS_OFF:          rd[0] = sys_off_q;
      default:               rd = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata              <= 32'h00000000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      slow_rc_en          <= 1'b0;
      slow_crystal_en     <= 1'b0;
      slow_crystal_ext    <= 1'b0;
      slow_crystal_bypass <= 1'b0;
      slow_synth_en       <= 1'b0;
      fast_clock_req      <= 1'b0;
      fast_crystal_en     <= 1'b0;
      slow_tick           <= 1'b0;
    end
    else
    begin
      // No wait states: ready rises in the first access cycle
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= rd;
      slow_rc_en <= running && (act_src_q == `LFC_SRC_RC ||
                    (act_src_q == `LFC_SRC_XTAL && !on_xtal_q));
      slow_crystal_en     <= running && act_src_q == `LFC_SRC_XTAL;
      slow_crystal_ext    <= running && src_snap_q[`LFC_EXTERNAL_BIT];
      slow_crystal_bypass <= running && src_snap_q[`LFC_BYPASS_BIT];
      slow_synth_en       <= running && act_src_q == `LFC_SRC_SYNTH;
      fast_clock_req      <= (running && act_src_q == `LFC_SRC_SYNTH) ||
                             cal_active || fast_run_q;
      fast_crystal_en     <= fast_run_q;
      slow_tick           <= running && tick;
    end
  end
endmodule // lfc_ctrl

// File: verif/lfc_ctrl_assertions.sv
// Port-level checker for the slow clock controller
`timescale 1ns/1ps
module lfc_ctrl_assertions (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic slow_rc_en,
  input logic slow_crystal_en,
  input logic slow_crystal_ext,
  input logic slow_crystal_bypass,
  input logic slow_synth_en,
  input logic fast_clock_req,
  input logic cal_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_no_err; !pslverr; endproperty
  a_no_err: assert property (p_no_err) else $error("slave error raised");
  property p_ready_acc; pready |-> psel && penable; endproperty
  a_ready_acc: assert property (p_ready_acc) else $error("ready outside access");
  // One wait state at most, so the bench never stalls on a silent slave
  property p_ready_next; psel && penable && !pready |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("ready late");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
  property p_synth_fast; slow_synth_en |-> fast_clock_req; endproperty
  a_synth_fast: assert property (p_synth_fast) else $error("synth without fast");
  property p_cal_ref; cal_active |-> fast_clock_req && slow_rc_en; endproperty
  a_cal_ref: assert property (p_cal_ref) else $error("cal without reference");
  property p_cal_end; $rose(cal_active) |-> ##[1:60] !cal_active; endproperty
  a_cal_end: assert property (p_cal_end) else $error("cal never ends");
  property p_byp_ext; slow_crystal_bypass |-> slow_crystal_ext; endproperty
  a_byp_ext: assert property (p_byp_ext) else $error("bypass without ext");
  property p_one_src; slow_synth_en |-> !slow_crystal_en; endproperty
  a_one_src: assert property (p_one_src) else $error("two sources");
  property p_xtal_rc; $rose(slow_crystal_en) |-> ##[0:2] slow_rc_en; endproperty
  a_xtal_rc: assert property (p_xtal_rc) else $error("no rc during start");
  c_cal: cover property ($fell(cal_active));
  c_synth: cover property (slow_synth_en);
  c_byp: cover property (slow_crystal_bypass);
endmodule // lfc_ctrl_assertions

// File: verif/low_freq_clock_controller_tb.sv
// Register-level testbench for the slow clock controller
`timescale 1ns/1ps
`include "lfc_consts.vh"
module low_freq_clock_controller_tb;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg         xtal_ready_pin = 1'b0;
  reg  [31:0] v;
  wire [31:0] prdata;
  wire        pready, pslverr, slow_rc_en, slow_crystal_en, slow_crystal_ext;
  wire        slow_crystal_bypass, slow_synth_en, fast_clock_req, fast_crystal_en;
  wire        slow_tick, cal_active;
  integer     bad_count = 0;
  integer     tests_run = 0;
  integer     n = 0;
  always #50 pclk = ~pclk;
  lfc_ctrl #(.SLOW_DIV(4), .XTAL_TICKS(2), .CAL_TICKS(2), .FAST_TICKS(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xtal_ready_pin(xtal_ready_pin),
    .slow_rc_en(slow_rc_en), .slow_crystal_en(slow_crystal_en),
    .slow_crystal_ext(slow_crystal_ext), .slow_crystal_bypass(slow_crystal_bypass),
    .slow_synth_en(slow_synth_en), .fast_clock_req(fast_clock_req),
    .fast_crystal_en(fast_crystal_en), .slow_tick(slow_tick), .cal_active(cal_active));
  task test_done;
    begin
      if (bad_count == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        $display("Error at %0t: got %h expected %h", $time, got, exp);
        bad_count = bad_count + 1;
      end
    end
  endtask
  // Held until pready is seen at an edge; read data taken at that edge
  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      v = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so the next call never drives psel twice in one step
      @(posedge pclk);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input [11:0] a, input [31:0] exp);
    begin
      xfer(1'b0, a, 32'h0);
      chk(v, exp);
    end
  endtask
  // Polls a field until it matches; the count only bounds a hang
  task wt(input [11:0] a, input [31:0] m, input [31:0] exp);
    integer i;
    begin
      xfer(1'b0, a, 32'h0);
      for (i = 0; i < 60 && (v & m) !== exp; i = i + 1)
        xfer(1'b0, a, 32'h0);
      chk(v & m, exp);
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count = bad_count + 1;
    test_done;
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({slow_rc_en, slow_crystal_en, slow_synth_en, cal_active}, 32'h0);
    rdc(`LFC_SRC_SEL, 32'h0);
    rdc(12'h7fc, 32'h0);
    wr(`LFC_START_SLOW_TASK, 32'h1);
    wt(`LFC_SLOW_STARTED_EVT, 32'h1, 32'h1);
    wt(`LFC_SLOW_STAT, 32'h10003, 32'h10000);
    chk(slow_rc_en, 32'h1);
    while (slow_tick !== 1'b1)
      @(posedge pclk);
    @(posedge pclk);
    n = 0;
    while (slow_tick !== 1'b1)
    begin
      n = n + 1;
      @(posedge pclk);
    end
    chk(n, 32'h3); // One tick per SLOW_DIV of 4 clocks
    wr(`LFC_SRC_SEL, 32'h2);
    rdc(`LFC_SRC_SEL, 32'h0);
    wr(`LFC_START_FAST_TASK, 32'h1);
    wt(`LFC_FAST_STARTED_EVT, 32'h1, 32'h1);
    chk(fast_crystal_en, 32'h1);
    wr(`LFC_CAL_TASK, 32'h1);
    wt(`LFC_CAL_DONE_EVT, 32'h1, 32'h1);
    wr(`LFC_CAL_DONE_EVT, 32'h0);
    rdc(`LFC_CAL_DONE_EVT, 32'h0);
    wr(`LFC_CAL_IV, 32'h3);
    rdc(`LFC_CAL_IV, 32'h3);
    wr(`LFC_TMR_START_TASK, 32'h1);
    rdc(`LFC_TIMEOUT_EVT, 32'h0);
    wt(`LFC_TIMEOUT_EVT, 32'h1, 32'h1);
    wr(`LFC_TIMEOUT_EVT, 32'h0);
    repeat (40) @(posedge pclk);
    rdc(`LFC_TIMEOUT_EVT, 32'h0);
    wr(`LFC_CAL_IV, 32'ha);
    wr(`LFC_TMR_START_TASK, 32'h1);
    // Tasks spaced by more than one slow period
    repeat (12) @(posedge pclk);
    wr(`LFC_TMR_STOP_TASK, 32'h1);
    repeat (80) @(posedge pclk);
    rdc(`LFC_TIMEOUT_EVT, 32'h0);
    wr(`LFC_STOP_SLOW_TASK, 32'h1);
    wt(`LFC_SLOW_STAT, 32'h10000, 32'h0);
    chk(slow_rc_en, 32'h0);
    wr(`LFC_SRC_SEL, 32'h10001);
    rdc(`LFC_SRC_SEL, 32'h0);
    wr(`LFC_SRC_SEL, 32'h20002);
    rdc(`LFC_SRC_SEL, 32'h0);
    wr(`LFC_SRC_SEL, 32'h30001);
    rdc(`LFC_SRC_SEL, 32'h30001);
    wr(`LFC_SLOW_STARTED_EVT, 32'h0);
    wr(`LFC_START_SLOW_TASK, 32'h1);
    rdc(`LFC_SRC_SNAP, 32'h30001);
    repeat (12) @(posedge pclk);
    rdc(`LFC_SLOW_STARTED_EVT, 32'h0);
    chk(slow_rc_en, 32'h1);
    xtal_ready_pin <= 1'b1;
    wt(`LFC_SLOW_STARTED_EVT, 32'h1, 32'h1);
    wt(`LFC_SLOW_STAT, 32'h10003, 32'h10001);
    chk({slow_crystal_en, slow_crystal_ext, slow_crystal_bypass, slow_rc_en}, 32'he);
    wr(`LFC_STOP_SLOW_TASK, 32'h1);
    wt(`LFC_SLOW_STAT, 32'h10000, 32'h0);
    xtal_ready_pin <= 1'b0;
    wr(`LFC_SRC_SEL, 32'h2);
    wr(`LFC_START_SLOW_TASK, 32'h1);
    wt(`LFC_SLOW_STAT, 32'h10003, 32'h10002);
    chk({slow_synth_en, fast_clock_req}, 32'h3);
    wr(`LFC_SYS_OFF, 32'h1);
    repeat (4) @(posedge pclk);
    chk({slow_rc_en, slow_crystal_en, slow_synth_en, cal_active, fast_clock_req,
         fast_crystal_en}, 32'h0);
    test_done;
  end
endmodule // low_freq_clock_controller_tb
bind lfc_ctrl lfc_ctrl_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .slow_rc_en(slow_rc_en),
  .slow_crystal_en(slow_crystal_en), .slow_crystal_ext(slow_crystal_ext),
  .slow_crystal_bypass(slow_crystal_bypass), .slow_synth_en(slow_synth_en),
  .fast_clock_req(fast_clock_req), .cal_active(cal_active));
